// ===== bdc_map.svh
`ifndef BDC_MAP_SVH
`define BDC_MAP_SVH
// Register offsets
`define BDC_A_DIM      8'h00
`define BDC_A_BST      8'h01
`define BDC_A_FSC      8'h02
`define BDC_A_REG      8'h03
`define BDC_A_BAL      8'h04
`define BDC_A_BAH      8'h05
`define BDC_A_BBL      8'h06
`define BDC_A_BBH      8'h07
// Reset values
`define BDC_RST_DIM    8'h4C
`define BDC_RST_BST    8'h76
`define BDC_RST_FSC    8'h92
`define BDC_RST_ZERO   8'h00
// Field positions
`define BDC_DIM_MIX    0
`define BDC_DIM_SRC    1
`define BDC_DIM_TH     3:2
`define BDC_DIM_SS     4
`define BDC_DIM_EDGE   6:5
`define BDC_BST_FSW    3:0
`define BDC_BST_ILIM   4
`define BDC_BST_OVP    6:5
`define BDC_BST_10B    7
`define BDC_REG_LDO    6:5
`define BDC_HI         1:0
`define BDC_HI_PAD     6'h00
// Dimming levels on a 10-bit scale, and the shift counts that stretch sub-threshold duty
`define BDC_FULL       10'h3FF
`define BDC_TH_0       10'h000
`define BDC_TH_6P25    10'h040
`define BDC_TH_12P5    10'h080
`define BDC_TH_25      10'h100
`define BDC_SH_6P25    3'h4
`define BDC_SH_12P5    3'h3
`define BDC_SH_25      3'h2
// Lowest nonzero full-scale code
`define BDC_FS_MIN     8'h49
// Clock rate and boost frequency plan in kHz
`define BDC_CLK_KHZ    18'h3D090
`define BDC_FSW_BASE   18'h0012C
`define BDC_FSW_STEP1  18'h00064
`define BDC_FSW_STEP2  18'h000C8
`define BDC_FSW_KNEE   4'h7
`define BDC_FSW_MAX    4'hC
// Forced switch-off point, 90 percent of a boost period
`define BDC_OFF_POINT  18'h36EE8
// Dimming counter prescale
`define BDC_DIM_DIV    4'hA
// Divider steps of the duty meter
`define BDC_MDIV_STEPS 4'hA
// Bus address of the block, arbitrary value
`define BDC_BUS_ADDR   7'h2A
`endif

// ===== bdc_pkg.sv
`default_nettype none
package bdc_pkg;
   typedef enum logic [2:0] {BDC_IDLE, BDC_ADDR, BDC_DATA, BDC_ACK, BDC_RD, BDC_RACK} bdc_bus_e;

   typedef struct packed {
      logic       scl;
      logic       sda;
      bdc_bus_e   st;
      logic [7:0] sh;
      logic [3:0] bc;
      logic       rw;
      logic       first;
      logic [7:0] ptr;
      logic       oen_n;
      logic       wr;
   } bdc_bus_s;

   typedef struct packed {
      logic        p;
      logic [19:0] hi;
      logic [19:0] per;
      logic [20:0] rem;
      logic [19:0] den;
      logic [9:0]  q;
      logic [3:0]  k;
      logic [9:0]  duty;
      logic        done;
   } bdc_meter_s;

   typedef struct packed {
      logic [7:0]  r0;
      logic [7:0]  r1;
      logic [7:0]  r2;
      logic [7:0]  r3;
      logic [7:0]  alo;
      logic [7:0]  ahi;
      logic [7:0]  blo;
      logic [7:0]  bhi;
      logic        pend;
      logic [9:0]  bri;
      logic [9:0]  d1;
      logic [9:0]  d2;
      logic [9:0]  dcnt;
      logic [3:0]  div;
      logic [17:0] acc;
      logic        gate;
      logic        sink;
      logic [9:0]  amp;
   } bdc_top_s;
endpackage
`default_nettype wire

// ===== bdc_bus_slave.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdc_map.svh"
module bdc_bus_slave
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oen_o,
   input  wire logic [7:0] rd_data_i,
   output logic      [7:0] addr_o,
   output logic      [7:0] wr_data_o,
   output logic            wr_o
);
   bdc_pkg::bdc_bus_s q;
   bdc_pkg::bdc_bus_s n;
   logic              rise;
   logic              fall;

   // Byte-wide serial slave: address, register pointer, then data bytes
   always_comb
   begin
      n       = q;
      n.scl   = scl_i;
      n.sda   = sda_i;
      n.wr    = 1'b0;
      rise    = scl_i & ~q.scl;
      fall    = ~scl_i & q.scl;
      if (q.wr)
         n.ptr = q.ptr + 8'h01;
      if (q.scl & scl_i & q.sda & ~sda_i)
      begin
         n.st    = bdc_pkg::BDC_ADDR;
         n.bc    = 4'h0;
         n.oen_n = 1'b1;
      end
      else if (q.scl & scl_i & ~q.sda & sda_i)
      begin
         n.st    = bdc_pkg::BDC_IDLE;
         n.oen_n = 1'b1;
      end
      else
      begin
         case (q.st)
            bdc_pkg::BDC_ADDR, bdc_pkg::BDC_DATA:
            begin
               if (rise)
               begin
                  n.sh = {q.sh[6:0], sda_i};
                  n.bc = q.bc + 4'h1;
               end
               else if (fall && q.bc == 4'h8)
               begin
                  n.bc    = 4'h0;
                  n.st    = bdc_pkg::BDC_ACK;
                  n.oen_n = 1'b0;
                  if (q.st == bdc_pkg::BDC_ADDR)
                  begin
                     n.rw    = q.sh[0];
                     n.first = 1'b1;
                     if (q.sh[7:1] != `BDC_BUS_ADDR)
                     begin
                        n.st    = bdc_pkg::BDC_IDLE;
                        n.oen_n = 1'b1;
                     end
                  end
                  else if (q.first)
                  begin
                     n.ptr   = q.sh;
                     n.first = 1'b0;
                  end
                  else
                     n.wr = 1'b1;
               end
            end
            bdc_pkg::BDC_ACK:
            begin
               if (fall)
               begin
                  n.oen_n = 1'b1;
                  n.st    = bdc_pkg::BDC_DATA;
                  if (q.rw)
                  begin
                     n.sh    = rd_data_i;
                     n.ptr   = q.ptr + 8'h01;
                     n.oen_n = rd_data_i[7];
                     n.st    = bdc_pkg::BDC_RD;
                  end
               end
            end
            bdc_pkg::BDC_RD:
            begin
               if (fall && q.bc == 4'h7)
               begin
                  n.bc    = 4'h0;
                  n.oen_n = 1'b1;
                  n.st    = bdc_pkg::BDC_RACK;
               end
               else if (fall)
               begin
                  n.sh    = {q.sh[6:0], 1'b0};
                  n.oen_n = q.sh[6];
                  n.bc    = q.bc + 4'h1;
               end
            end
            bdc_pkg::BDC_RACK:
            begin
               if (rise)
                  n.st = sda_i ? bdc_pkg::BDC_IDLE : bdc_pkg::BDC_ACK;
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         q <= '{scl: 1'b1, sda: 1'b1, st: bdc_pkg::BDC_IDLE, oen_n: 1'b1, default: '0};
      else
         q <= n;
   end

   assign sda_o     = 1'b0;
   assign sda_oen_o = q.oen_n;
   assign addr_o    = q.ptr;
   assign wr_data_o = q.sh;
   assign wr_o      = q.wr;
endmodule
`default_nettype wire

// ===== bdc_duty_meter.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdc_map.svh"
module bdc_duty_meter
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       pwm_i,
   output logic      [9:0] duty_o,
   output logic            done_o
);
   bdc_pkg::bdc_meter_s q;
   bdc_pkg::bdc_meter_s n;
   logic [20:0]         r2;

   // Count high and period cycles, then divide serially at each rising edge
   always_comb
   begin
      n      = q;
      n.p    = pwm_i;
      n.done = 1'b0;
      r2     = {q.rem[19:0], 1'b0};
      if (q.per != 20'hFFFFF)
      begin
         n.per = q.per + 20'h00001;
         n.hi  = q.hi + {19'h00000, pwm_i};
      end
      if (pwm_i & ~q.p)
      begin
         n.per = 20'h00001;
         n.hi  = 20'h00001;
         n.den = q.per;
         n.rem = {1'b0, q.hi};
         n.q   = 10'h000;
         n.k   = `BDC_MDIV_STEPS;
         if (q.hi >= q.per)
         begin
            n.k    = 4'h0;
            n.duty = `BDC_FULL;
            n.done = 1'b1;
         end
      end
      else if (q.k != 4'h0)
      begin
         n.k = q.k - 4'h1;
         if (r2 >= {1'b0, q.den})
         begin
            n.rem = r2 - {1'b0, q.den};
            n.q   = {q.q[8:0], 1'b1};
         end
         else
         begin
            n.rem = r2;
            n.q   = {q.q[8:0], 1'b0};
         end
         if (q.k == 4'h1)
         begin
            n.duty = n.q;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         q <= '0;
      else
         q <= n;
   end

   assign duty_o = q.duty;
   assign done_o = q.done;
endmodule
`default_nettype wire

// ===== bdc_top.sv
// Contract
// (RULE_01) PWM mode: sinks switch on and off with the PWM input.
// (RULE_02) DC mode: amplitude applied two input periods late, from averaged duty.
// (RULE_03) 25% mixed mode, duty 25% to 100%: amplitude follows duty.
// (RULE_04) 25% mixed mode, duty below 25%: quarter amplitude, on-time modulated.
// (RULE_05) Dimming control bit 1 picks PWM pin or brightness pair A.
// (RULE_06) Bit 4 enables spread spectrum; bits 6:5 pick switch edge rate.
// (RULE_07) Boost config bits 3:0 set switching frequency, 300 kHz to 2 MHz.
// (RULE_08) Boost config bit 4 selects 1.5 A or 2.5 A current limit.
// (RULE_09) Over-limit current turns the switch off until the next oscillator cycle.
// (RULE_10) Boost config bits 6:5 select 25, 28, 32 or 36 V over-voltage.
// (RULE_11) Switch held off while output is over threshold, resumes below it.
// (RULE_12) Full-scale code: 0 is off, 01h to 49h clamp, default 92h.
// (RULE_13) Regulator register bits 6:5 select 3.2, 3.4, 3.6 or 4.6 V.
// (RULE_14) Boost config bit 7 selects 8-bit or 10-bit brightness.
// (RULE_15) Two brightness pairs: low byte plus two high bits each.
// (RULE_16) In 10-bit mode brightness changes only after low then high write.
// (RULE_17) Bit 0 picks PWM or mixed; bits 3:2 set mixed threshold.
// (RULE_18) 10-bit value is high bits above low byte; 8-bit uses low byte.
`timescale 1ns/1ps
`default_nettype none
`include "bdc_map.svh"
module bdc_top
(
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oen_o,
   input  wire logic       pwm_i,
   input  wire logic       over_current_i,
   input  wire logic       over_voltage_i,
   output logic            sink_en_o,
   output logic      [9:0] string_amp_o,
   output logic      [7:0] string_current_o,
   output logic            switch_node_gate_o,
   output logic            spread_en_o,
   output logic      [1:0] edge_rate_o,
   output logic            ilim_high_o,
   output logic      [1:0] over_voltage_threshold_o,
   output logic      [1:0] linear_regulator_o
);
   bdc_pkg::bdc_top_s q;
   bdc_pkg::bdc_top_s n;
   logic [7:0]        ba;
   logic [7:0]        wd;
   logic              wr;
   logic [7:0]        rd;
   logic [9:0]        m_duty;
   logic              m_done;
   logic [9:0]        duty;
   logic [9:0]        th;
   logic [9:0]        scaled;
   logic [17:0]       khz;
   logic [17:0]       acc_nx;
   logic              tick;

   // Boost frequency of a code in kHz, codes above the top one clamp
   function automatic logic [17:0] fsw_khz(input logic [3:0] code);
      logic [3:0] c;
      c = (code > `BDC_FSW_MAX) ? `BDC_FSW_MAX : code;
      if (c <= `BDC_FSW_KNEE)
         fsw_khz = 18'(`BDC_FSW_BASE + `BDC_FSW_STEP1 * {14'h0000, c});
      else
         fsw_khz = 18'(`BDC_FSW_BASE + `BDC_FSW_STEP1 * {14'h0000, `BDC_FSW_KNEE}
                       + `BDC_FSW_STEP2 * {14'h0000, c - `BDC_FSW_KNEE});
   endfunction

   // Mixed-mode threshold on the 10-bit duty scale
   function automatic logic [9:0] mix_th(input logic [1:0] code);
      case (code)
         2'h0:    mix_th = `BDC_TH_0;
         2'h1:    mix_th = `BDC_TH_6P25;
         2'h2:    mix_th = `BDC_TH_12P5;
         default: mix_th = `BDC_TH_25;
      endcase
   endfunction

   // Stretch of a sub-threshold duty so on-time times amplitude keeps the average
   function automatic logic [2:0] mix_sh(input logic [1:0] code);
      case (code)
         2'h1:    mix_sh = `BDC_SH_6P25;
         2'h2:    mix_sh = `BDC_SH_12P5;
         default: mix_sh = `BDC_SH_25;
      endcase
   endfunction

   // On phase of the internal dimming waveform
   function automatic logic pwm_on(input logic [9:0] cnt, input logic [9:0] d);
      pwm_on = (d == `BDC_FULL) || (cnt < d);
   endfunction

   bdc_bus_slave bdc_bus_slave_i
   (
      .clk_i     (clk_i),
      .resetn_i  (resetn_i),
      .scl_i     (scl_i),
      .sda_i     (sda_i),
      .sda_o     (sda_o),
      .sda_oen_o (sda_oen_o),
      .rd_data_i (rd),
      .addr_o    (ba),
      .wr_data_o (wd),
      .wr_o      (wr)
   );

   bdc_duty_meter bdc_duty_meter_i
   (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .pwm_i    (pwm_i),
      .duty_o   (m_duty),
      .done_o   (m_done)
   );

   // Read decode, unmapped offsets read zero
   always_comb
   begin
      if (ba == `BDC_A_DIM)
         rd = q.r0;
      else if (ba == `BDC_A_BST)
         rd = q.r1;
      else if (ba == `BDC_A_FSC)
         rd = q.r2;
      else if (ba == `BDC_A_REG)
         rd = q.r3;
      else if (ba == `BDC_A_BAL)
         rd = q.alo;
      else if (ba == `BDC_A_BAH)
         rd = q.ahi;
      else if (ba == `BDC_A_BBL)
         rd = q.blo;
      else if (ba == `BDC_A_BBH)
         rd = q.bhi;
      else
         rd = `BDC_RST_ZERO;
   end

   // Register writes, brightness commit, dimming and boost switch control
   always_comb
   begin
      n      = q;
      khz    = fsw_khz(q.r1[`BDC_BST_FSW]);                             // RULE_07
      acc_nx = q.acc + khz;
      tick   = acc_nx >= `BDC_CLK_KHZ;
      duty   = q.r0[`BDC_DIM_SRC] ? q.bri : q.d2;                       // RULE_05
      th     = mix_th(q.r0[`BDC_DIM_TH]);                               // RULE_17
      scaled = duty << mix_sh(q.r0[`BDC_DIM_TH]);
      if (wr)
      begin
         n.pend = 1'b0;
         if (ba == `BDC_A_DIM)
            n.r0 = wd;
         else if (ba == `BDC_A_BST)
            n.r1 = wd;
         else if (ba == `BDC_A_FSC)
            n.r2 = wd;
         else if (ba == `BDC_A_REG)
            n.r3 = wd;
         else if (ba == `BDC_A_BAL)
         begin
            n.alo  = wd;                                                // RULE_15
            n.pend = q.r1[`BDC_BST_10B];                                // RULE_14 RULE_16
            if (!q.r1[`BDC_BST_10B])
               n.bri = {wd, wd[7:6]};                                   // RULE_18
         end
         else if (ba == `BDC_A_BAH)
         begin
            n.ahi = {`BDC_HI_PAD, wd[`BDC_HI]};                         // RULE_15
            if (q.pend && q.r1[`BDC_BST_10B])
               n.bri = {wd[`BDC_HI], q.alo};                            // RULE_16
         end
         else if (ba == `BDC_A_BBL)
            n.blo = wd;
         else if (ba == `BDC_A_BBH)
            n.bhi = {`BDC_HI_PAD, wd[`BDC_HI]};
      end
      // Averaged duty runs through two period stages
      if (m_done)
      begin
         n.d1 = m_duty;                                                 // RULE_02
         n.d2 = q.d1;
      end
      // Internal dimming waveform counter
      n.div = q.div + 4'h1;
      if (q.div == `BDC_DIM_DIV - 4'h1)
      begin
         n.div  = 4'h0;
         n.dcnt = q.dcnt + 10'h001;
      end
      // Sink enable and amplitude per dimming mode
      if (!q.r0[`BDC_DIM_MIX])
      begin
         n.amp  = `BDC_FULL;
         n.sink = q.r0[`BDC_DIM_SRC] ? pwm_on(q.dcnt, q.bri) : pwm_i;   // RULE_01
      end
      else if (duty >= th)
      begin
         n.amp  = duty;                                                 // RULE_03
         n.sink = duty != 10'h000;
      end
      else
      begin
         n.amp  = th;                                                   // RULE_04
         n.sink = pwm_on(q.dcnt, scaled);
      end
      // Boost oscillator, current limit and over-voltage gating
      n.acc = tick ? acc_nx - `BDC_CLK_KHZ : acc_nx;
      if (tick)
         n.gate = !over_current_i && !over_voltage_i;                   // RULE_11
      else if (over_current_i || over_voltage_i || q.acc >= `BDC_OFF_POINT)
         n.gate = 1'b0;                                                 // RULE_09
   end

   always_ff @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         q <= '{r0: `BDC_RST_DIM, r1: `BDC_RST_BST, r2: `BDC_RST_FSC, default: '0};
      else
         q <= n;
   end

   // Analog settings driven straight from the registers, full-scale code clamped at its low end
   assign spread_en_o              = q.r0[`BDC_DIM_SS];                 // RULE_06
   assign edge_rate_o              = q.r0[`BDC_DIM_EDGE];               // RULE_06
   assign ilim_high_o              = q.r1[`BDC_BST_ILIM];               // RULE_08
   assign over_voltage_threshold_o = q.r1[`BDC_BST_OVP];                // RULE_10
   assign linear_regulator_o       = q.r3[`BDC_REG_LDO];                // RULE_13
   assign string_current_o         = (q.r2 != `BDC_RST_ZERO && q.r2 < `BDC_FS_MIN)
                                     ? `BDC_FS_MIN : q.r2;              // RULE_12
   assign switch_node_gate_o       = q.gate;
   assign sink_en_o                = q.sink;
   assign string_amp_o             = q.amp;

   a_pwm_follow: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_01
      (!q.r0[`BDC_DIM_MIX] && !q.r0[`BDC_DIM_SRC]) |=> (sink_en_o == $past(pwm_i)))
      else $error("sink does not follow pwm pin");
   a_dc_delay: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_02
      (m_done && q.r0[`BDC_DIM_MIX] && !q.r0[`BDC_DIM_SRC]
       && q.r0[`BDC_DIM_TH] == 2'h0) |=> ##1 (string_amp_o == $past(q.d1, 2)))
      else $error("dc amplitude not two periods late");
   a_mix_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_03
      (q.r0[`BDC_DIM_MIX] && duty >= th && duty != 10'h000)
      |=> (sink_en_o && string_amp_o == $past(duty)))
      else $error("mixed amplitude not equal to duty");
   a_mix_low: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_04
      (q.r0[`BDC_DIM_MIX] && q.r0[`BDC_DIM_TH] == 2'h3 && duty < `BDC_TH_25)
      |=> (string_amp_o == `BDC_TH_25))
      else $error("low duty amplitude not one quarter");
   a_src_reg: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_05
      (!q.r0[`BDC_DIM_MIX] && q.r0[`BDC_DIM_SRC] && q.bri == `BDC_FULL)
      |=> sink_en_o)
      else $error("register source full scale not on");
   a_osc_on: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_07
      (tick && !over_current_i && !over_voltage_i) |=> switch_node_gate_o)
      else $error("switch not turned on by oscillator");
   a_ilim_off: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_09
      (over_current_i && !tick) |=> !switch_node_gate_o)
      else $error("switch not off on over current");
   a_ovp_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_11
      over_voltage_i |=> !switch_node_gate_o)
      else $error("switch not held off on over voltage");
   a_pair_commit: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_16
      (wr && ba == `BDC_A_BAL && q.r1[`BDC_BST_10B]) |=> $stable(q.bri))
      else $error("brightness changed before high byte");
   a_fs_clamp: assert property (@(posedge clk_i) disable iff (!resetn_i) // RULE_12
      (q.r2 == 8'h01) |-> (string_current_o == `BDC_FS_MIN))
      else $error("full scale code not clamped");
endmodule
`default_nettype wire

// ===== bdc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module bdc_host_model
(
   input  wire logic       clk_i,
   input  wire logic       sda_i,
   output logic            scl_o,
   output logic            sda_o,
   output logic      [7:0] res_o,
   output logic            res_stb_o
);
   initial
   begin
      scl_o = 1'b1;
      sda_o = 1'b1;
      res_o = 8'h00;
      res_stb_o = 1'b0;
   end
   // Bus phases last five system clocks, slow against the sampler
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Data changes only while the bus clock is low
   task automatic bit_io(input logic b, output logic r);
      sda_o = b;
      hold(5);
      scl_o = 1'b1;
      hold(5);
      r = sda_i;
      scl_o = 1'b0;
      hold(5);
   endtask
   task automatic start();
      sda_o = 1'b1;
      hold(5);
      scl_o = 1'b1;
      hold(5);
      sda_o = 1'b0;
      hold(5);
      scl_o = 1'b0;
      hold(5);
   endtask
   task automatic stop();
      sda_o = 1'b0;
      hold(5);
      scl_o = 1'b1;
      hold(5);
      sda_o = 1'b1;
      hold(5);
   endtask
   // Send a byte, MSB first, then release the line for the acknowledge
   task automatic tx(input logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
   endtask
   // Receive a byte and answer with a not-acknowledge to end the read
   task automatic rx(output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(1'b1, r);
   endtask
   // Write: address, pointer, data
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d);
      start();
      tx({dev, 1'b0});
      tx(a);
      tx(d);
      stop();
   endtask
   // Read: set pointer, repeated start, one byte; result shown as a strobe
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] a);
      logic [7:0] d;
      start();
      tx({dev, 1'b0});
      tx(a);
      start();
      tx({dev, 1'b1});
      rx(d);
      stop();
      res_o = d;
      hold(1);
      res_stb_o = 1'b1;
      hold(1);
      res_stb_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== test_bdc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdc_map.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_count++; \
 $display("Error %s expected %0h seen %0h", nm, e, g); end end
module test_bdc_top;
   logic       clk_i, resetn_i, pwm_i, oc, ov, scl, hsda, sda_oen, sda_o, sink, gate;
   logic       spread, ilim, res_stb, p;
   logic [1:0] edge_r, ovp, linear_regulator;
   logic [7:0] fsc, res, v;
   logic [9:0] amp;
   logic [7:0] exp_q[$];
   logic [31:0] seed = 32'h18B5F909;
   int         err_count = 0, n_compared = 0, k;
   wire logic  sda = hsda & (sda_oen | sda_o);
   bdc_top bdc_top_i (.clk_i(clk_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
      .sda_o(sda_o), .sda_oen_o(sda_oen), .pwm_i(pwm_i), .over_current_i(oc),
      .over_voltage_i(ov), .sink_en_o(sink), .string_amp_o(amp), .string_current_o(fsc),
      .switch_node_gate_o(gate), .spread_en_o(spread), .edge_rate_o(edge_r),
      .ilim_high_o(ilim), .over_voltage_threshold_o(ovp), .linear_regulator_o(linear_regulator));
   bdc_host_model bdc_host_model_i (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_o(hsda),
      .res_o(res), .res_stb_o(res_stb));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic summarize();
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bdc_host_model_i.write_reg(`BDC_BUS_ADDR, a, d);
   endtask
   // Note the expected byte, then read it back over the bus
   task automatic rd(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      bdc_host_model_i.read_reg(dev, a);
   endtask
   // Wait a bounded time for the boost switch to reach a level
   task automatic wait_gate(input logic lv);
      k = 0;
      while (gate !== lv && k < 1000)
      begin
         @(posedge clk_i);
         #1;
         k++;
      end
      if (k == 1000) begin err_count++; $display("Error gate wait"); summarize(); end
   endtask
   // Read results compared against the oldest note
   always @(posedge res_stb)
   begin
      if (exp_q.size() == 0) begin err_count++; $display("Error read unexpected"); end
      else `CHK("read", exp_q.pop_front(), res)
   end
   initial
   begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   initial
   begin
      {resetn_i, pwm_i, oc, ov} = 4'h0;
      repeat (10) @(posedge clk_i);
      #1;
      resetn_i = 1'b1;
      `CHK("fields", 8'h5C, {spread, edge_r, ilim, ovp, linear_regulator})
      `CHK("fsc", 8'h92, fsc)
      rd(`BDC_BUS_ADDR, `BDC_A_DIM, `BDC_RST_DIM);
      rd(`BDC_BUS_ADDR, `BDC_A_BST, `BDC_RST_BST);
      rd(`BDC_BUS_ADDR, `BDC_A_FSC, `BDC_RST_FSC);
      for (int a = 3; a < 9; a++) rd(`BDC_BUS_ADDR, a[7:0], 8'h00);
      rd(7'h2B, `BDC_A_DIM, 8'hFF);
      // Pin source, PWM mode: sinks track the pin one clock late
      p = 1'b0;
      repeat (300)
      begin
         @(posedge clk_i);
         #1;
         `CHK("sink", p, sink)
         p = rnd() % 7 > 2;
         pwm_i = p;
      end
      // Register readback and field outputs with random contents
      repeat (4)
      begin
         v = rnd();
         wr(`BDC_A_DIM, v);
         `CHK("fields0", {v[4], v[6:5]}, {spread, edge_r})
         rd(`BDC_BUS_ADDR, `BDC_A_DIM, v);
         v = {v[7:4], 4'(rnd() % 13)};
         wr(`BDC_A_BST, v);
         `CHK("fields1", {ilim, ovp}, {v[4], v[6:5]})
         rd(`BDC_BUS_ADDR, `BDC_A_BST, v);
         v = rnd();
         wr(`BDC_A_REG, v);
         `CHK("ldo", linear_regulator, v[6:5])
         wr(`BDC_A_BBL, v + 8'h11);
         wr(`BDC_A_BBH, v & 8'h03);
         rd(`BDC_BUS_ADDR, `BDC_A_BBL, v + 8'h11);
         rd(`BDC_BUS_ADDR, `BDC_A_BBH, v & 8'h03);
      end
      // Full-scale code: zero, clamped low code 01h, top code
      wr(`BDC_A_FSC, 8'h00);
      `CHK("fsc0", fsc, 8'h00)
      wr(`BDC_A_FSC, 8'h01);
      `CHK("fsc1", fsc, `BDC_FS_MIN)
      wr(`BDC_A_FSC, 8'hFF);
      `CHK("fscF", fsc, 8'hFF)
      // Register source at zero brightness ignores a busy pin
      wr(`BDC_A_BST, `BDC_RST_BST);
      wr(`BDC_A_DIM, 8'h4E);
      wr(`BDC_A_BAL, 8'h00);
      k = 0;
      repeat (300)
      begin
         @(posedge clk_i);
         #1;
         pwm_i = rnd();
         k += sink;
      end
      `CHK("src", 0, k)
      // Register source: 8-bit full scale, then a 10-bit pair commits on the high byte
      wr(`BDC_A_BAL, 8'hFF);
      `CHK("src8", 1'b1, sink)
      wr(`BDC_A_BAL, 8'h00);
      wr(`BDC_A_BST, 8'hF6);
      wr(`BDC_A_BAL, 8'hFF);
      `CHK("pair_lo", 1'b0, sink)
      wr(`BDC_A_BAH, 8'h03);
      `CHK("pair_hi", 1'b1, sink)
      wr(`BDC_A_BST, `BDC_RST_BST);
      // Mixed mode at 25 percent threshold from register levels
      wr(`BDC_A_DIM, 8'h4F);
      `CHK("mix_full", 10'h3FF, amp)
      wr(`BDC_A_BAL, 8'h20);
      `CHK("mix_low", 10'h100, amp)
      wr(`BDC_A_BAL, 8'h80);
      `CHK("mix_mid", 10'h202, amp)
      // DC mode from the pin: half duty gives half amplitude
      wr(`BDC_A_DIM, 8'h41);
      repeat (6)
      begin
         pwm_i = 1'b1;
         repeat (10) @(posedge clk_i);
         #1;
         pwm_i = 1'b0;
         repeat (10) @(posedge clk_i);
         #1;
      end
      `CHK("dc_amp", 10'h200, amp)
      `CHK("dc_sink", 1'b1, sink)
      // Over-current then over-voltage force the switch off and hold it off
      for (int i = 0; i < 2; i++)
      begin
         wait_gate(1'b1);
         if (i == 0) oc = 1'b1;
         else ov = 1'b1;
         repeat (3) @(posedge clk_i);
         #1;
         `CHK("gate_off", gate, 1'b0)
         k = 0;
         repeat (900)
         begin
            @(posedge clk_i);
            #1;
            k += gate;
         end
         `CHK("gate_held", k, 0)
         {oc, ov} = 2'b00;
         wait_gate(1'b1);
      end
      if (exp_q.size() != 0) begin err_count++; $display("Error read missing"); end
      summarize();
   end
endmodule
`default_nettype wire
